/* hdl/ebrw_pkg.sv */
// Constants and types for the external bus ready and arbitration block
// Overview of operation
// - Software selects ready input active polarity.
// - Synchronous ready sampled directly, shortest cycle.
// - Asynchronous ready adds a stage, one wait.
// - Inactive ready sampled inserts another wait state.
// - Active ready sampled ends the running cycle.
// - Ready evaluated only after mandatory waits elapse.
// - Enabled arbitration yields bus on hold request.
// - Running cycle finishes before bus is granted.
// - Release drives controls inactive, then floats them.
// - Regain request only after bus is released.
// - Regain starts only when hold goes high.
// - Hold withdrawn unasked still runs regain sequence.
// - Regain drives controls inactive before next cycle.
// - Read data latched on strobe ending edge.
package ebrw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_WDATA  = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_RDATA  = 8'h14;

  // Control and command field positions
  localparam int CTRL_POL      = 0;
  localparam int CTRL_ASYNC    = 1;
  localparam int CTRL_RDY_EN   = 2;
  localparam int CTRL_ARB_EN   = 3;
  localparam int CTRL_REGAIN   = 4;
  localparam int CTRL_WAIT_LSB = 8;
  localparam int CMD_START     = 0;
  localparam int CMD_WRITE     = 1;

  // Reset value and response codes
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Pin synchroniser depth and domain crossing depth
  localparam int PIN_STAGES  = 3;
  localparam int SYNC_STAGES = 2;

  // Bus cycle settings carried with each request
  typedef struct packed {
    logic       pol;
    logic       async;
    logic       rdy_en;
    logic [3:0] waits;
  } ebrw_cfg_type;

  typedef struct packed {
    logic [23:0]  addr;
    logic [15:0]  wdata;
    logic         write;
    ebrw_cfg_type cfg;
  } ebrw_req_type;

  // Bus engine states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ALE     = 3'b001,
    ST_STROBE  = 3'b010,
    ST_RELEASE = 3'b011,
    ST_FLOAT   = 3'b100,
    ST_REGAIN  = 3'b101
  } ebrw_state_type;

endpackage : ebrw_pkg

/* hdl/ebrw_top.sv */
// External bus cycle engine with ready waits and hold arbitration
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module ebrw_top (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  link_clock,
  // AXI4-Lite slave
  input  wire logic [7:0]            awaddr,
  input  wire logic                  awvalid,
  output      logic                  awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output      logic                  wready,
  output      logic [1:0]            bresp,
  output      logic                  bvalid,
  input  wire logic                  bready,
  input  wire logic [7:0]            araddr,
  input  wire logic                  arvalid,
  output      logic                  arready,
  output      logic [31:0]           rdata,
  output      logic [1:0]            rresp,
  output      logic                  rvalid,
  input  wire logic                  rready,
  // External bus pins
  output      logic                  bus_reference_clock_out,
  output      logic [23:0]           addr_out,
  output      logic                  addr_oe,
  output      logic [15:0]           data_out,
  output      logic                  data_oe,
  input  wire logic [15:0]           data_in,
  output      logic                  ale_out,
  output      logic                  rd_n_out,
  output      logic                  wr_n_out,
  output      logic                  ctrl_oe,
  input  wire logic                  ready_in,
  input  wire logic                  hold_n_in,
  output      logic                  bus_grant_ack_out,
  output      logic                  bus_regain_request_out
);
  import ebrw_pkg::*;

  // ---------------- System clock domain ----------------
  logic [31:0]      ctrl;
  ebrw_req_type     req;
  logic             busy;
  logic             start_tgl;
  logic [15:0]      rdata_reg;
  logic [SYNC_STAGES-1:0] done_sync, grant_sync, bus_regain_request_out_sync;
  logic             done_seen;
  logic             aw_held, w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic [15:0]      link_rdata;
  logic             done_tgl;

  // Write path handshake
  wire do_write  = aw_held && w_held && !bvalid;
  wire do_read   = arvalid && arready;
  wire sel_ctrl  = aw_addr == OFS_CTRL;
  wire sel_addr  = aw_addr == OFS_ADDR;
  wire sel_wdata = aw_addr == OFS_WDATA;
  wire sel_cmd   = aw_addr == OFS_CMD;
  wire w_mapped  = sel_ctrl || sel_addr || sel_wdata || sel_cmd;
  wire done_evt  = done_sync[SYNC_STAGES-1] != done_seen;
  wire cmd_go    = do_write && sel_cmd && w_strb[0] &&
                   w_data[CMD_START] && !busy;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                       {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] ctrl_new = (ctrl & ~wmask) | (w_data & wmask);
  wire [31:0] addr_new = ({8'h00, req.addr} & ~wmask) | (w_data & wmask);
  wire [31:0] wd_new   = ({16'h0000, req.wdata} & ~wmask) |
                         (w_data & wmask);

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  // Read decode
  wire [31:0] status_word = {28'h0000000, bus_regain_request_out_sync[SYNC_STAGES-1],
                             1'b0, grant_sync[SYNC_STAGES-1], busy};
  wire r_ctrl  = araddr == OFS_CTRL;
  wire r_stat  = araddr == OFS_STATUS;
  wire r_addr  = araddr == OFS_ADDR;
  wire r_wd    = araddr == OFS_WDATA;
  wire r_cmd   = araddr == OFS_CMD;
  wire r_rd    = araddr == OFS_RDATA;
  wire r_map   = r_ctrl || r_stat || r_addr || r_wd || r_cmd || r_rd;
  wire [31:0] r_word = r_ctrl ? ctrl :
                       r_stat ? status_word :
                       r_addr ? {8'h00, req.addr} :
                       r_wd   ? {16'h0000, req.wdata} :
                       r_rd   ? {16'h0000, rdata_reg} : 32'h0000_0000;

  // Address and data channel holding
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= {awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Responses
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end else begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (do_read) begin
        rvalid <= 1'b1;
        rresp  <= r_map ? RESP_OKAY : RESP_SLVERR;
        rdata  <= r_word;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Control register, writable at any time, and latched request; address and data frozen while a cycle runs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      req  <= '0;
    end else begin
      if (do_write && sel_ctrl) begin
        ctrl <= ctrl_new;
      end
      if (do_write && sel_addr && !busy) begin
        req.addr <= addr_new[23:0];
      end
      if (do_write && sel_wdata && !busy) begin
        req.wdata <= wd_new[15:0];
      end
      if (cmd_go) begin
        req.write      <= w_data[CMD_WRITE];
        req.cfg.pol    <= ctrl[CTRL_POL];
        req.cfg.async  <= ctrl[CTRL_ASYNC];
        req.cfg.rdy_en <= ctrl[CTRL_RDY_EN];
        req.cfg.waits  <= ctrl[CTRL_WAIT_LSB +: 4];
      end
    end
  end

  // Start toggle, done sync, busy flag and status syncs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      start_tgl  <= 1'b0;
      busy       <= 1'b0;
      done_sync  <= '0;
      done_seen  <= 1'b0;
      grant_sync <= '0;
      bus_regain_request_out_sync  <= '0;
      rdata_reg  <= 16'h0000;
    end else begin
      done_sync  <= {done_sync[0], done_tgl};
      grant_sync <= {grant_sync[0], bus_grant_ack_out};
      bus_regain_request_out_sync  <= {bus_regain_request_out_sync[0], bus_regain_request_out};
      done_seen  <= done_sync[SYNC_STAGES-1];
      if (cmd_go) begin
        start_tgl <= ~start_tgl;
        busy      <= 1'b1;
      end else if (done_evt) begin
        busy      <= 1'b0;
        rdata_reg <= link_rdata;
      end
    end
  end

  // ---------------- Link clock domain ----------------
  logic [1:0]            lrst_sync;
  logic [PIN_STAGES-1:0] rdy_pin, hold_pin;
  logic                  rdy_filt, hold_filt, rdy_async;
  logic [SYNC_STAGES-1:0] start_sync, arb_sync, regain_sync;
  logic                  start_seen;
  logic [3:0]            wait_cnt;
  ebrw_state_type        state, next_state;

  wire lrst_n = lrst_sync[1];

  assign bus_reference_clock_out = link_clock;

  // Reset release into link domain
  always_ff @(posedge link_clock or negedge nrst) begin
    if (!nrst) begin
      lrst_sync <= 2'b00;
    end else begin
      lrst_sync <= {lrst_sync[0], 1'b1};
    end
  end

  // Pin synchronisers; a change counts when stages two and three agree
  always_ff @(posedge link_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      rdy_pin     <= '0;
      hold_pin    <= '1;
      rdy_filt    <= 1'b0;
      hold_filt   <= 1'b1;
      rdy_async   <= 1'b0;
      start_sync  <= '0;
      arb_sync    <= '0;
      regain_sync <= '0;
    end else begin
      rdy_pin     <= {rdy_pin[1:0], ready_in};
      hold_pin    <= {hold_pin[1:0], hold_n_in};
      if (rdy_pin[2] == rdy_pin[1]) rdy_filt <= rdy_pin[2];
      if (hold_pin[2] == hold_pin[1]) hold_filt <= hold_pin[2];
      rdy_async   <= rdy_filt;
      start_sync  <= {start_sync[0], start_tgl};
      arb_sync    <= {arb_sync[0], ctrl[CTRL_ARB_EN]};
      regain_sync <= {regain_sync[0], ctrl[CTRL_REGAIN]};
    end
  end

  // Ready qualification by mode and polarity
  wire rdy_level = req.cfg.async ? rdy_async : rdy_filt;
  wire rdy_ok    = req.cfg.pol ? rdy_level : !rdy_level;
  wire pending   = start_sync[SYNC_STAGES-1] != start_seen;
  wire hold_act  = !hold_filt;
  wire arb_en    = arb_sync[SYNC_STAGES-1];
  wire want_bus  = pending || regain_sync[SYNC_STAGES-1];
  wire waits_done = wait_cnt == 4'h0;
  wire cyc_end   = waits_done && (!req.cfg.rdy_en || rdy_ok);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (arb_en && hold_act) next_state = ST_RELEASE;
        else if (pending)       next_state = ST_ALE;
      end
      ST_ALE:     next_state = ST_STROBE;
      ST_STROBE: begin
        if (cyc_end) next_state = ST_IDLE;
      end
      ST_RELEASE: next_state = ST_FLOAT;
      ST_FLOAT: begin
        if (!hold_act) next_state = ST_REGAIN;
      end
      ST_REGAIN:  next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  // State, wait counter and handshake bookkeeping
  always_ff @(posedge link_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      state      <= ST_IDLE;
      wait_cnt   <= 4'h0;
      start_seen <= 1'b0;
      done_tgl   <= 1'b0;
      link_rdata <= 16'h0000;
    end else begin
      state <= next_state;
      if (state == ST_ALE) begin
        wait_cnt   <= req.cfg.waits;
        start_seen <= start_sync[SYNC_STAGES-1];
      end else if (state == ST_STROBE && !waits_done) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      if (state == ST_STROBE && cyc_end) begin
        done_tgl <= ~done_tgl;
        if (!req.write) link_rdata <= data_in;
      end
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge link_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      addr_out <= 24'h000000;
      addr_oe  <= 1'b1;
      data_out <= 16'h0000;
      data_oe  <= 1'b0;
      ale_out  <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      ctrl_oe  <= 1'b1;
      bus_grant_ack_out      <= 1'b0;
      bus_regain_request_out <= 1'b0;
    end else begin
      ale_out  <= next_state == ST_ALE;
      rd_n_out <= !(next_state == ST_STROBE && !req.write);
      wr_n_out <= !(next_state == ST_STROBE && req.write);
      data_oe  <= next_state == ST_STROBE && req.write;
      if (next_state == ST_ALE) begin
        addr_out <= req.addr;
        data_out <= req.wdata;
      end
      ctrl_oe  <= next_state != ST_FLOAT;
      addr_oe  <= next_state != ST_FLOAT;
      bus_grant_ack_out <= next_state == ST_FLOAT;
      bus_regain_request_out <= next_state == ST_FLOAT &&
                                state == ST_FLOAT && want_bus;
    end
  end

  // ---------------- Checks on the link side ----------------
  mand_wait_hold_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && !waits_done |=> state == ST_STROBE)
    else $error("cycle ended during mandatory waits");

  ready_wait_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && waits_done && req.cfg.rdy_en && !rdy_ok
    |=> state == ST_STROBE && (rd_n_out ^ wr_n_out))
    else $error("inactive ready did not add a wait state");

  ready_end_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && waits_done && rdy_ok
    |=> state == ST_IDLE && rd_n_out && wr_n_out)
    else $error("active ready did not end the cycle");

  async_stage_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && req.cfg.async && req.cfg.rdy_en &&
    (rdy_async != req.cfg.pol) |=> state == ST_STROBE)
    else $error("async ready ended cycle without its extra stage");

  polarity_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && waits_done && req.cfg.rdy_en &&
    !req.cfg.async && rdy_filt == !req.cfg.pol |=> state == ST_STROBE)
    else $error("ready polarity ignored");

  hold_after_cycle_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE |=> ctrl_oe && !bus_grant_ack_out)
    else $error("bus granted during a running cycle");

  release_order_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    $fell(ctrl_oe) |-> !$past(ale_out) && $past(rd_n_out) &&
    $past(wr_n_out) && bus_grant_ack_out)
    else $error("controls floated without being driven inactive");

  regain_seq_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_FLOAT && !hold_act
    |=> state == ST_REGAIN ##1 state == ST_IDLE && ctrl_oe &&
    !ale_out && rd_n_out && wr_n_out)
    else $error("regain sequence not run on hold removal");

  bus_regain_request_out_point_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    bus_regain_request_out |-> !ctrl_oe && $past(state) == ST_FLOAT)
    else $error("regain request before the bus was released");

  read_capture_a: assert property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && cyc_end && !req.write
    |=> link_rdata == $past(data_in))
    else $error("read data not taken on the strobe ending edge");

  cover_read_c: cover property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && cyc_end && !req.write);
  cover_ready_wait_c: cover property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_STROBE && waits_done && req.cfg.rdy_en && !rdy_ok);
  cover_float_c: cover property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_FLOAT && bus_regain_request_out);
  cover_regain_c: cover property (
    @(posedge link_clock) disable iff (!lrst_n)
    state == ST_REGAIN ##1 state == ST_IDLE && ctrl_oe);

endmodule : ebrw_top

/* tb/ebrw_far_model.sv */
// Far-side peripheral and competing bus master model
`timescale 1ns/100ps
module ebrw_far_model (
  input  wire logic        lclk,
  input  wire logic [23:0] addr_out,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        rd_n_out,
  input  wire logic        wr_n_out,
  input  wire logic        pol,
  input  wire logic [3:0]  delay,
  input  wire logic        hold_req,
  output      logic        ready_in,
  output      logic        hold_n_in,
  output      logic [15:0] data_in,
  output      logic [4:0]  last_len = 5'h00,
  output      logic [23:0] w_addr = 24'h000000,
  output      logic [15:0] w_data = 16'h0000,
  output      logic        w_oe = 1'b0,
  output      logic [7:0]  n_wr = 8'h00
);
  logic       rdy = 1'b0;
  logic [4:0] cnt = 5'h00;
  logic [15:0] junk = 16'h0000;
  wire        strobe = !rd_n_out || !wr_n_out;
  // Competing master may drop hold whenever it likes
  assign hold_n_in = !hold_req;
  // Ready level follows the chosen polarity
  assign ready_in = pol ? rdy : !rdy;
  // Read data valid while the read strobe is low, changing otherwise
  assign data_in = !rd_n_out ? (addr_out[15:0] ^ 16'h5A3C) : junk;
  // Strobe timing, ready, write capture and read data
  always @(posedge lclk) begin
    cnt <= strobe ? cnt + 5'h01 : 5'h00;
    rdy <= strobe && (cnt >= {1'b0, delay});
    if (!strobe && cnt != 5'h00) begin
      last_len <= cnt;
    end
    if (!wr_n_out) begin
      w_addr <= addr_out;
      w_data <= data_out;
      w_oe   <= data_oe;
    end
    if (!wr_n_out && cnt == 5'h00) begin
      n_wr <= n_wr + 8'h01;
    end
    // Idle data lines keep changing
    junk <= ~junk;
  end
endmodule : ebrw_far_model

/* tb/ebrw_top_tb.sv */
// Self-checking bench for the external bus ready and arbitration block
`timescale 1ns/100ps
module ebrw_top_tb;
  import ebrw_pkg::*;
  logic        clock = 1'b0;
  logic        link_clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        hold_req = 1'b0, pol = 1'b1;
  logic [3:0]  delay = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        bus_reference_clock_out, addr_oe, data_oe, ale_out;
  logic        rd_n_out, wr_n_out, ctrl_oe, ready_in, hold_n_in;
  logic        bus_grant_ack_out, bus_regain_request_out;
  logic [23:0] addr_out, w_addr;
  logic [15:0] data_out, data_in, w_data;
  logic [4:0]  last_len;
  logic        w_oe;
  logic [7:0]  n_wr;
  logic        p_oe = 1'b1, p_g = 1'b0;
  logic [2:0]  p_ctl = 3'b110;
  int          n_errors = 0;
  int          cmp_count = 0;

  // System clock 8 ns, bus clock 30 ns
  always #4 clock = ~clock;
  always #15 link_clock = ~link_clock;

  ebrw_top u_ebrw_top (.clock, .nrst, .link_clock, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .bus_reference_clock_out, .addr_out, .addr_oe, .data_out, .data_oe,
    .data_in, .ale_out, .rd_n_out, .wr_n_out, .ctrl_oe, .ready_in,
    .hold_n_in, .bus_grant_ack_out, .bus_regain_request_out);

  ebrw_far_model u_ebrw_far_model (.lclk(bus_reference_clock_out),
    .addr_out, .data_out, .data_oe, .rd_n_out, .wr_n_out, .pol, .delay,
    .hold_req, .ready_in, .hold_n_in, .data_in, .last_len, .w_addr,
    .w_data, .w_oe, .n_wr);

  // Expected control word and read pattern
  function automatic logic [31:0] ctrl_word(input logic pl, as, re, ar, rg,
                                            input logic [3:0] wt);
    return {20'h0, wt, 3'h0, rg, ar, re, as, pl};
  endfunction : ctrl_word

  function automatic logic [31:0] exp_rd(input logic [23:0] a);
    return {16'h0, a[15:0] ^ 16'h5A3C};
  endfunction : exp_rd

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize;
    $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic ah, wh, bh;
    int   n;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bh = 1'b0;
    n = 0;
    while (!bh && n < 100) begin
      @(negedge clock);
      ah = awvalid && awready === 1'b1;
      wh = wvalid && wready === 1'b1;
      bh = bvalid === 1'b1;
      if (bh) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
      n++;
    end
    if (!bh) chk("bvalid", 32'h1, 32'h0);
  endtask : axi_wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ah, rh;
    int   n;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rh = 1'b0;
    n = 0;
    while (!rh && n < 100) begin
      @(negedge clock);
      ah = arvalid && arready === 1'b1;
      rh = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
      n++;
    end
    if (!rh) chk("rvalid", 32'h1, 32'h0);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd_chk

  task automatic wait_idle;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && n < 100) begin
      rd(OFS_STATUS, d, r);
      n++;
    end
    chk("busy", 32'h0, {31'h0, d[0]});
  endtask : wait_idle

  task automatic wait_grant(input logic v);
    int n;
    n = 0;
    while (bus_grant_ack_out !== v && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk("grant", {31'h0, v}, {31'h0, bus_grant_ack_out});
  endtask : wait_grant

  // One bus cycle through the registers, checked at both ends
  task automatic run(input logic w, pl, as, re, input logic [3:0] wt, dl,
                     input logic [23:0] ad, input logic [15:0] dt);
    logic [7:0]  nw;
    logic [31:0] d;
    logic [1:0]  r;
    pol   <= pl;
    delay <= dl;
    nw = n_wr;
    axi_wr(OFS_CTRL, ctrl_word(pl, as, re, 1'b0, 1'b0, wt), RESP_OKAY);
    axi_wr(OFS_ADDR, {8'h0, ad}, RESP_OKAY);
    axi_wr(OFS_WDATA, {16'h0, dt}, RESP_OKAY);
    axi_wr(OFS_CMD, {30'h0, w, 1'b1}, RESP_OKAY);
    wait_idle();
    if (re) begin
      chk("ready_wait", 32'h1, {31'h0, last_len > {1'b0, dl}});
      chk("mand_wait", 32'h1, {31'h0, last_len > {1'b0, wt}});
    end else begin
      chk("strobe_len", {27'h0, 5'(wt) + 5'h01}, {27'h0, last_len});
    end
    if (w) begin
      chk("wr_addr", {8'h0, ad}, {8'h0, w_addr});
      chk("wr_data", {16'h0, dt}, {16'h0, w_data});
      chk("wr_oe", 32'h1, {31'h0, w_oe});
      chk("wr_count", {24'h0, nw + 8'h01}, {24'h0, n_wr});
    end else begin
      rd(OFS_RDATA, d, r);
      chk("rdata", exp_rd(ad), d);
    end
  endtask : run

  // Control pins around release and regain of the bus
  always @(negedge link_clock) begin
    if (p_oe && ctrl_oe === 1'b0) chk("release", 32'h6, {29'h0, p_ctl});
    if (!p_oe && ctrl_oe === 1'b1) chk("regain", 32'hC, {28'h0, rd_n_out, wr_n_out, ale_out, bus_grant_ack_out});
    if (!p_g && bus_grant_ack_out === 1'b1) chk("float", 32'h0, {30'h0, ctrl_oe, addr_oe});
    p_oe  <= ctrl_oe;
    p_g   <= bus_grant_ack_out;
    p_ctl <= {rd_n_out, wr_n_out, ale_out};
  end

  // Watchdog
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    logic [4:0]  ls;
    logic [7:0]  nw;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    void'($urandom(33));
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (16) @(posedge clock);
    rd_chk(OFS_CTRL, CTRL_RESET, RESP_OKAY, "ctrl_reset");
    rd_chk(OFS_STATUS, 32'h0, RESP_OKAY, "status_reset");
    axi_wr(OFS_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    rd_chk(OFS_CTRL, 32'hFFFF_FFFF, RESP_OKAY, "ctrl_rw");
    axi_wr(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    rd_chk(8'h40, 32'h0, RESP_SLVERR, "unmapped");
    rd_chk(OFS_CMD, 32'h0, RESP_OKAY, "cmd_read");
    run(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 24'hFFFFFF, 16'h0000);
    run(1'b1, 1'b1, 1'b0, 1'b0, 4'hF, 4'h0, 24'h000000, 16'hFFFF);
    run(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h5, 24'h00C0DE, 16'h0000);
    run(1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 4'h2, 24'h001234, 16'h0000);
    ls = last_len;
    run(1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 4'h2, 24'h004321, 16'h0000);
    chk("async_slower", 32'h1, {31'h0, last_len > ls});
    for (int i = 0; i < 12; i++) begin
      run(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
          4'($urandom_range(3)), 4'($urandom_range(7)), 24'($urandom),
          16'($urandom));
    end
    // Hold ignored while arbitration is off
    hold_req <= 1'b1;
    repeat (40) @(posedge clock);
    chk("no_grant", 32'h0, {31'h0, bus_grant_ack_out});
    run(1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 4'h0, 24'h00ABCD, 16'h0000);
    hold_req <= 1'b0;
    repeat (20) @(posedge clock);
    // Hold arriving in mid-cycle
    axi_wr(OFS_CTRL, ctrl_word(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0), RESP_OKAY);
    delay <= 4'h7;
    nw = n_wr;
    axi_wr(OFS_CMD, 32'h3, RESP_OKAY);
    n = 0;
    while (wr_n_out !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk("strobe_seen", 32'h0, {31'h0, wr_n_out});
    hold_req <= 1'b1;
    wait_grant(1'b1);
    chk("cycle_done", {24'h0, nw + 8'h01}, {24'h0, n_wr});
    rd_chk(OFS_STATUS, 32'h2, RESP_OKAY, "status_grant");
    axi_wr(OFS_CTRL, ctrl_word(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0), RESP_OKAY);
    repeat (40) @(posedge clock);
    chk("regain_req", 32'h1, {31'h0, bus_regain_request_out});
    chk("still_held", 32'h1, {31'h0, bus_grant_ack_out});
    rd_chk(OFS_STATUS, 32'hA, RESP_OKAY, "status_regain");
    hold_req <= 1'b0;
    wait_grant(1'b0);
    chk("regain_drop", 32'h0, {31'h0, bus_regain_request_out});
    // Hold withdrawn without a regain request
    axi_wr(OFS_CTRL, ctrl_word(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0), RESP_OKAY);
    hold_req <= 1'b1;
    wait_grant(1'b1);
    hold_req <= 1'b0;
    wait_grant(1'b0);
    run(1'b0, 1'b1, 1'b0, 1'b0, 4'h2, 4'h0, 24'h005555, 16'h0000);
    summarize();
  end
endmodule : ebrw_top_tb
